// *** shared/input_select_pkg.sv ***
/*
  Shared constants and types of the capture unit input selection block.
  Assumes a 32-bit AXI4-Lite register bus with byte addressing.
*/
package input_select_pkg;

  // printed offsets are not all multiples of four: kept as indices
  localparam logic [7:0] SELECT_LOW_INDEX = 8'h9E;
  localparam logic [7:0] SELECT_HIGH_INDEX = 8'h9F;
  localparam logic [11:0] SELECT_LOW_ADDR = {2'h0, SELECT_LOW_INDEX, 2'h0};
  localparam logic [11:0] SELECT_HIGH_ADDR = {2'h0, SELECT_HIGH_INDEX, 2'h0};
  localparam int ADDR_WIDTH = 12;

  localparam logic [7:0] SELECT_LOW_RESET = 8'h00;
  localparam logic [7:0] SELECT_HIGH_RESET = 8'h00;

  // field positions (low bit of each two-bit field)
  localparam int CAPTURE0_POS = 0;
  localparam int CAPTURE1_POS = 2;
  localparam int CAPTURE2_POS = 4;
  localparam int TRAP_POS = 6;
  localparam int HALL0_POS = 0;
  localparam int HALL1_POS = 2;
  localparam int HALL2_POS = 4;
  localparam int TIMER12_RUN_POS = 6;

  // synchroniser depth and resulting delay
  localparam int SYNC_STAGES = 2;
  localparam int SYNC_DELAY_NS = 40;
  localparam int CLOCK_PERIOD_NS = 20;
  localparam int SYNC_DELAY_CYCLES = SYNC_DELAY_NS / CLOCK_PERIOD_NS;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // raw candidate sources, all asynchronous to aclk
  typedef struct packed {
    logic [1:0] capture0_pins;
    logic [1:0] capture1_pins;
    logic [1:0] capture2_pins;
    logic trap_pin;
    logic overcurrent;
    logic [2:0] hall0_pins;
    logic [2:0] hall1_pins;
    logic [1:0] hall2_pins;
    logic timer12_run_pin;
    logic service_request_2;
    logic service_request_3;
    logic [2:0] adc_boundary;
    logic adc_trap_event;
    logic adc_run_event;
  } sources_type;

  // routed, synchronised module inputs
  typedef struct packed {
    logic capture_channel0;
    logic capture_channel1;
    logic capture_channel2;
    logic trap_input;
    logic hall_position0;
    logic hall_position1;
    logic hall_position2;
    logic timer12_hw_run;
  } selected_type;

endpackage

// *** logic/sync_two_stage.sv ***
/*
  Two flip-flop synchroniser for one level.
  Assumes din may change at any time relative to aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module sync_two_stage (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic din,
  output logic dout
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule
`default_nettype wire

// *** logic/mux_four_way.sv ***
/*
  Four-way selector driven by a two-bit code.
  Assumes inputs already synchronised to the caller's clock.
*/
`timescale 1ns/1ps
`default_nettype none
module mux_four_way (
  input wire logic [1:0] code,
  input wire logic [3:0] choices,
  output logic picked
);
  assign picked = choices[code];
endmodule
`default_nettype wire

// *** logic/capture_unit_input_select.sv ***
/*
  Input selection for the capture/compare timer unit: two select
  registers on AXI4-Lite, pin synchronisers and per-input selectors.
  Assumes all source signals are asynchronous and the sub-selection of
  trap and run pins is done outside this block.
*/
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module capture_unit_input_select (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire input_select_pkg::sources_type sources,
  output var input_select_pkg::selected_type selected
);
  logic [7:0] select_low_q;
  logic [7:0] select_high_q;
  logic [11:0] awaddr_q;
  logic aw_held_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic w_held_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // ---------------- write channel ----------------
  wire write_go = aw_held_q && w_held_q && !bvalid_q;
  wire hit_low_w = awaddr_q == input_select_pkg::SELECT_LOW_ADDR;
  wire hit_high_w = awaddr_q == input_select_pkg::SELECT_HIGH_ADDR;
  wire write_low = write_go && hit_low_w && wlane_q;
  wire write_high = write_go && hit_high_w && wlane_q;

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (write_go) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wbyte_q <= s_axi_wdata[7:0];
      wlane_q <= s_axi_wstrb[0];
    end else if (write_go) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= input_select_pkg::RESP_OKAY;
    end else if (write_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= (hit_low_w || hit_high_w) ? input_select_pkg::RESP_OKAY
                                           : input_select_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      select_low_q <= input_select_pkg::SELECT_LOW_RESET;
      select_high_q <= input_select_pkg::SELECT_HIGH_RESET;
    end else begin
      if (write_low) begin
        select_low_q <= wbyte_q;
      end
      if (write_high) begin
        select_high_q <= wbyte_q;
      end
    end
  end

  // ---------------- read channel ----------------
  wire read_go = s_axi_arvalid && s_axi_arready;
  wire hit_low_r = s_axi_araddr == input_select_pkg::SELECT_LOW_ADDR;
  wire hit_high_r = s_axi_araddr == input_select_pkg::SELECT_HIGH_ADDR;
  wire [7:0] read_byte = hit_low_r ? select_low_q : (hit_high_r ? select_high_q : 8'h00);

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= input_select_pkg::RESP_OKAY;
    end else if (read_go) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, read_byte};
      rresp_q <= (hit_low_r || hit_high_r) ? input_select_pkg::RESP_OKAY
                                           : input_select_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------- synchronisers ----------------
  localparam int SRC_W = $bits(input_select_pkg::sources_type);
  logic [SRC_W-1:0] raw_bits;
  logic [SRC_W-1:0] sync_bits;
  input_select_pkg::sources_type src_s;
  assign raw_bits = sources;
  assign src_s = sync_bits;

  genvar gi;
  generate
    for (gi = 0; gi < SRC_W; gi++) begin : g_sync
      sync_two_stage sync_i (
        .aclk(aclk),
        .aresetn(aresetn),
        .din(raw_bits[gi]),
        .dout(sync_bits[gi])
      );
    end
  endgenerate

  // ---------------- selectors ----------------
  wire [1:0] cap0_code = select_low_q[input_select_pkg::CAPTURE0_POS +: 2];
  wire [1:0] cap1_code = select_low_q[input_select_pkg::CAPTURE1_POS +: 2];
  wire [1:0] cap2_code = select_low_q[input_select_pkg::CAPTURE2_POS +: 2];
  wire [1:0] trap_code = select_low_q[input_select_pkg::TRAP_POS +: 2];
  wire [1:0] hall0_code = select_high_q[input_select_pkg::HALL0_POS +: 2];
  wire [1:0] hall1_code = select_high_q[input_select_pkg::HALL1_POS +: 2];
  wire [1:0] hall2_code = select_high_q[input_select_pkg::HALL2_POS +: 2];
  wire [1:0] run_code = select_high_q[input_select_pkg::TIMER12_RUN_POS +: 2];

  // code 10 combines trap pin and overcurrent
  wire trap_either = src_s.trap_pin | src_s.overcurrent;

  logic [7:0] choice_pick;
  logic [1:0] code_vec [8];
  logic [3:0] choice_vec [8];
  assign code_vec[0] = cap0_code;
  assign code_vec[1] = cap1_code;
  assign code_vec[2] = cap2_code;
  assign code_vec[3] = trap_code;
  assign code_vec[4] = hall0_code;
  assign code_vec[5] = hall1_code;
  assign code_vec[6] = hall2_code;
  assign code_vec[7] = run_code;
  assign choice_vec[0] = {src_s.adc_boundary[0], src_s.service_request_2,
                          src_s.capture0_pins};
  assign choice_vec[1] = {src_s.adc_boundary[1], src_s.service_request_2,
                          src_s.capture1_pins};
  assign choice_vec[2] = {src_s.adc_boundary[2], src_s.service_request_2,
                          src_s.capture2_pins};
  assign choice_vec[3] = {src_s.adc_trap_event, trap_either, src_s.overcurrent,
                          src_s.trap_pin};
  // hall 0 pins, code 11 reads low
  assign choice_vec[4] = {1'b0, src_s.hall0_pins};
  assign choice_vec[5] = {1'b0, src_s.hall1_pins};
  // hall 2, unused code 10 reads low
  assign choice_vec[6] = {src_s.adc_boundary[2], 1'b0, src_s.hall2_pins};
  assign choice_vec[7] = {src_s.adc_run_event, src_s.service_request_3,
                          src_s.service_request_2, src_s.timer12_run_pin};

  generate
    for (gi = 0; gi < 8; gi++) begin : g_mux
      mux_four_way mux_i (
        .code(code_vec[gi]),
        .choices(choice_vec[gi]),
        .picked(choice_pick[gi])
      );
    end
  endgenerate

  // selected outputs are registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      selected <= '0;
    end else begin
      selected <= {choice_pick[0], choice_pick[1], choice_pick[2], choice_pick[3],
                   choice_pick[4], choice_pick[5], choice_pick[6], choice_pick[7]};
    end
  end

  // ---------------- assertions ----------------
  capture_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cap0_code == 2'h2) |=> selected.capture_channel0 == $past(src_s.service_request_2))
    else $error("capture 0 not routed to service request 2");
  capture0_adc_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cap0_code == 2'h3) |=> selected.capture_channel0 == $past(src_s.adc_boundary[0]))
    else $error("capture 0 not routed to adc boundary");
  capture1_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cap1_code == 2'h3) |=> selected.capture_channel1 == $past(src_s.adc_boundary[1]))
    else $error("capture 1 not routed to adc boundary");
  capture1_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cap1_code == 2'h0) |=> selected.capture_channel1 == $past(src_s.capture1_pins[0]))
    else $error("capture 1 not routed to pin 0");
  capture2_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cap2_code == 2'h1) |=> selected.capture_channel2 == $past(src_s.capture2_pins[1]))
    else $error("capture 2 not routed to pin 1");
  capture2_adc_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cap2_code == 2'h3) |=> selected.capture_channel2 == $past(src_s.adc_boundary[2]))
    else $error("capture 2 not routed to adc boundary");
  trap_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (trap_code == 2'h1) |=> selected.trap_input == $past(src_s.overcurrent))
    else $error("trap not routed to overcurrent");
  trap_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (trap_code == 2'h0) |=> selected.trap_input == $past(src_s.trap_pin))
    else $error("trap not routed to trap pin");
  trap_adc_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (trap_code == 2'h3) |=> selected.trap_input == $past(src_s.adc_trap_event))
    else $error("trap not routed to adc event");
  trap_combine_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (trap_code == 2'h2 && trap_either) |=> selected.trap_input)
    else $error("combined trap not raised");
  trap_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (trap_code == 2'h2 && !trap_either) |=> !selected.trap_input)
    else $error("combined trap raised with both sources low");
  hall0_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (hall0_code == 2'h2) |=> selected.hall_position0 == $past(src_s.hall0_pins[2]))
    else $error("hall 0 not routed to pin 2");
  hall0_pin1_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (hall0_code == 2'h1) |=> selected.hall_position0 == $past(src_s.hall0_pins[1]))
    else $error("hall 0 not routed to pin 1");
  hall2_unused_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (hall2_code == 2'h2) |=> !selected.hall_position2)
    else $error("hall 2 unused code not low");
  hall2_adc_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (hall2_code == 2'h3) |=> selected.hall_position2 == $past(src_s.adc_boundary[2]))
    else $error("hall 2 not routed to adc boundary");
  run_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (run_code == 2'h2) |=> selected.timer12_hw_run == $past(src_s.service_request_3))
    else $error("run not routed to service request 3");
  run_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (run_code == 2'h0) |=> selected.timer12_hw_run == $past(src_s.timer12_run_pin))
    else $error("run not routed to pin group");
  run_adc_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (run_code == 2'h3) |=> selected.timer12_hw_run == $past(src_s.adc_run_event))
    else $error("run not routed to adc event");
  reset_zero_a: assert property (@(posedge aclk)
    !aresetn |=> select_low_q == 8'h00 && select_high_q == 8'h00)
    else $error("select registers not zero after reset");
  sync_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##2 src_s.service_request_2 == $past(sources.service_request_2, 2))
    else $error("synchroniser delay not two cycles");
  write_effect_a: assert property (@(posedge aclk) disable iff (!aresetn)
    write_low |=> select_low_q == $past(wbyte_q))
    else $error("low register write lost");
  high_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    write_high |=> select_high_q == $past(wbyte_q))
    else $error("high register write lost");
endmodule
`default_nettype wire

// *** verification/source_model.sv ***
/*
  Model of the candidate sources: pins, service requests, ADC events and
  the overcurrent detector, all plain levels.
  Assumes the bench changes the wanted levels right after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module source_model (
  input wire logic [$bits(input_select_pkg::sources_type)-1:0] want,
  output var input_select_pkg::sources_type sources
);
  // levels are driven steadily; no source here has a released state
  assign sources = input_select_pkg::sources_type'(want);
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
/*
  Bench for the capture unit input selection: register access over
  AXI4-Lite and routing of every source under every select code.
  Assumes the source model feeds the block's source port.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int SW = $bits(input_select_pkg::sources_type);
  localparam logic [11:0] LO = input_select_pkg::SELECT_LOW_ADDR;
  localparam logic [11:0] HI = input_select_pkg::SELECT_HIGH_ADDR;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, data;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [SW-1:0] want, pat;
  logic [7:0] lo_v, hi_v;
  input_select_pkg::sources_type sources, one;
  input_select_pkg::selected_type selected;
  int err_total = 0;
  int check_count = 0;
  int cycle_q = 0;
  logic [7:0] codes [6] = '{8'h00, 8'h55, 8'hAA, 8'hFF, 8'hE4, 8'h1B};

  source_model partner (.want(want), .sources(sources));
  capture_unit_input_select DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sources(sources), .selected(selected)
  );

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycle_q <= cycle_q + 1;
    if (cycle_q == 30000) begin
      err_total++;
      final_report;
    end
  end

  task final_report;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task check_sel(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic pick(input logic [1:0] c, input logic [3:0] v);
    return v[c];
  endfunction

  // reference routing, one choice vector per selector
  function automatic input_select_pkg::selected_type exp_sel(input logic [7:0] lo,
      input logic [7:0] hi, input input_select_pkg::sources_type s);
    input_select_pkg::selected_type e;
    e.capture_channel0 = pick(lo[1:0], {s.adc_boundary[0], s.service_request_2, s.capture0_pins});
    e.capture_channel1 = pick(lo[3:2], {s.adc_boundary[1], s.service_request_2, s.capture1_pins});
    e.capture_channel2 = pick(lo[5:4], {s.adc_boundary[2], s.service_request_2, s.capture2_pins});
    e.trap_input = pick(lo[7:6], {s.adc_trap_event, s.trap_pin | s.overcurrent, s.overcurrent,
      s.trap_pin});
    e.hall_position0 = pick(hi[1:0], {1'b0, s.hall0_pins});
    e.hall_position1 = pick(hi[3:2], {1'b0, s.hall1_pins});
    e.hall_position2 = pick(hi[5:4], {s.adc_boundary[2], 1'b0, s.hall2_pins});
    e.timer12_hw_run = pick(hi[7:6], {s.adc_run_event, s.service_request_3, s.service_request_2,
      s.timer12_run_pin});
    return e;
  endfunction

  task axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task axi_read(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    data = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    want = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(LO);
    check_word("low reset", 32'h00000000, data);
    axi_read(HI);
    check_word("high reset", 32'h00000000, data);
    #1 check_sel("selected reset", 8'h00, selected);
    $display("test reset done");
    axi_write(LO, 32'hFFFFFFFF, 4'hF);
    check_word("write resp", 32'h0, {30'h0, resp});
    axi_write(LO, 32'h00000000, 4'hE);
    axi_read(LO);
    check_word("low lanes", 32'h000000FF, data);
    axi_write(12'h000, 32'h000000FF, 4'hF);
    check_word("unmapped write", 32'h2, {30'h0, resp});
    axi_read(12'h000);
    check_word("unmapped read", 32'h2, {30'h0, resp});
    check_word("unmapped data", 32'h00000000, data);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(LO);
    check_word("low after reset", 32'h00000000, data);
    $display("test registers done");
    one = '0;
    one.capture0_pins = 2'h1;
    @(posedge aclk);
    want <= one;
    repeat (input_select_pkg::SYNC_DELAY_CYCLES) @(posedge aclk);
    #1 check_sel("sync early", 8'h00, selected);
    @(posedge aclk);
    #1 check_sel("sync due", exp_sel(8'h00, 8'h00, one), selected);
    $display("test synchroniser done");
    for (int k = 0; k < 6; k++) begin
      lo_v = codes[k];
      hi_v = codes[5-k];
      axi_write(LO, {24'h0, lo_v}, 4'hF);
      axi_write(HI, {24'h0, hi_v}, 4'hF);
      axi_read(HI);
      check_word("high rw", {24'h0, hi_v}, data);
      for (int i = 0; i < 2 * SW; i++) begin
        pat = '0;
        pat[i % SW] = 1'b1;
        if (i >= SW)
          pat = ~pat;
        @(posedge aclk);
        want <= pat;
        repeat (4) @(posedge aclk);
        #1 check_sel("route", exp_sel(lo_v, hi_v, pat), selected);
      end
    end
    $display("test routing done");
    final_report;
  end
endmodule
`default_nettype wire
